// *** src/uart_regs_pkg.sv ***
package uart_regs_pkg;
  // register offsets
  localparam logic [2:0] OFS_HOLD = 3'h0;
  localparam logic [2:0] OFS_IEN = 3'h1;
  localparam logic [2:0] OFS_ISTAT = 3'h2;
  localparam logic [2:0] OFS_LCTRL = 3'h3;
  localparam logic [2:0] OFS_MCTRL = 3'h4;
  localparam logic [2:0] OFS_LSTAT = 3'h5;
  localparam logic [2:0] OFS_MSTAT = 3'h6;
  localparam logic [2:0] OFS_SCRATCH = 3'h7;
  // reset values
  localparam logic [7:0] RST_DIV_LOW = 8'h01;
  localparam logic [7:0] RST_DIV_HIGH = 8'h00;
  localparam logic [3:0] RST_IEN = 4'h0;
  localparam logic [7:0] RST_LCTRL = 8'h00;
  localparam logic [7:0] RST_MCTRL = 8'h00;
  localparam logic [7:0] RST_SCRATCH = 8'h00;
  localparam logic [7:0] RST_ISTAT = 8'h01;
  // field positions
  localparam int IEN_RX_DATA = 0;
  localparam int IEN_TX_EMPTY = 1;
  localparam int IEN_LINE = 2;
  localparam int IEN_MODEM = 3;
  localparam int LCTRL_DIV_EN = 7;
  localparam int LCTRL_PAR_EN = 3;
  localparam int LCTRL_STOP = 2;
  localparam int FCTRL_EN = 0;
  localparam int FCTRL_RX_RST = 1;
  localparam int FCTRL_TX_RST = 2;
  localparam int FCTRL_TRIG_LO = 6;
  // interrupt source codes, highest priority first
  localparam logic [3:0] SRC_LINE = 4'h6;
  localparam logic [3:0] SRC_TIMEOUT = 4'hc;
  localparam logic [3:0] SRC_RX_DATA = 4'h4;
  localparam logic [3:0] SRC_TX_READY = 4'h2;
  localparam logic [3:0] SRC_MODEM = 4'h0;
  localparam logic [3:0] SRC_NONE = 4'h1;
  // receive timeout: four characters plus twelve bit times
  localparam logic [6:0] TMO_CHARS = 7'h04;
  localparam logic [6:0] TMO_BITS = 7'h0c;
  localparam logic [6:0] FRAME_BASE_BITS = 7'h07;
endpackage

// *** src/rx_timeout_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module rx_timeout_timer (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // control
  input wire logic i_enable,
  input wire logic i_restart,
  input wire logic i_bit_tick,
  input wire logic [6:0] i_limit,
  // result
  output logic o_expired
);
  logic [6:0] count_q;
  logic [6:0] count_d;
  logic expired_d;
  wire hit = (count_q >= i_limit);

  // counts bit times of silence; a new character or a read starts over
  always_comb begin
    count_d = count_q;
    expired_d = o_expired;
    if (i_restart || !i_enable) begin
      count_d = 7'h00;
      expired_d = 1'b0;
    end else if (hit) begin
      expired_d = 1'b1;
    end else if (i_bit_tick) begin
      count_d = count_q + 7'h01;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      count_q <= 7'h00;
      o_expired <= 1'b0;
    end else begin
      count_q <= count_d;
      o_expired <= expired_d;
    end
  end
endmodule
`default_nettype wire

// *** src/uart_regs_irq_enable.sv ***
// Behaviour
// - four enable bits gate five sources into status
// - rx data: holding full or trigger reached
// - tx ready on empty, also on enabling
// - line status bits 1-4 raise interrupt
// - modem enable bit; enables reset to zero
// - fifo rx interrupt follows trigger level
// - status and output clear below trigger
// - data ready set on entry, clear empty
// - polled mode: status readable without interrupts
// - overrun sets line status bit 1
// - bits 2-4 report head character errors
// - bit5 holding empty, bit6 all empty
// - bit7 any error anywhere in fifo
// - status read returns highest pending source
// - status bit0 low while interrupt pending
// - each source clears by its own access
// - timeout after four chars twelve bits
// - any modem delta raises modem interrupt
`timescale 1ns/1ps
`default_nettype none
module uart_regs_irq_enable (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // host register port
  input wire logic [2:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_irq,
  // receive engine status
  input wire logic i_rx_char_in,
  input wire logic [7:0] i_rx_head,
  input wire logic i_rx_empty,
  input wire logic [7:0] i_rx_level,
  input wire logic i_rx_overrun,
  input wire logic i_rx_head_parity_err,
  input wire logic i_rx_head_framing_err,
  input wire logic i_rx_head_break,
  input wire logic i_rx_any_err,
  input wire logic [1:0] i_trig_scale,
  input wire logic i_bit_tick,
  // transmit engine status
  input wire logic i_tx_holding_empty,
  input wire logic i_tx_all_empty,
  // modem pins, active low
  input wire logic i_cts_b,
  input wire logic i_dsr_b,
  input wire logic i_ri_b,
  input wire logic i_cd_b,
  // engine controls
  output logic o_rx_pop,
  output logic o_tx_push,
  output logic [7:0] o_tx_data,
  output logic o_fifo_en,
  output logic o_rx_fifo_reset,
  output logic o_tx_fifo_reset,
  output logic [7:0] o_line_control,
  output logic [7:0] o_modem_control,
  output logic [15:0] o_divisor
);
  // host written registers
  logic [3:0] ien_q;
  logic [7:0] div_low_q;
  logic [7:0] div_high_q;
  logic [7:0] scratch_q;
  logic [1:0] trig_sel_q;

  // sticky interrupt flags and their next values
  logic overrun_q;
  logic overrun_d;
  logic tx_pend_q;
  logic tx_pend_d;
  logic tx_empty_prev_q;

  // modem pin pipeline, one bit per pin
  logic [3:0] modem_meta_q;
  logic [3:0] modem_sync_q;
  logic [3:0] modem_prev_q;
  logic [3:0] delta_q;
  wire [3:0] delta_d;

  // decoded and selected values
  logic [3:0] src_code;
  logic [7:0] trig_level;
  logic [7:0] rd_mux;
  logic timeout;

  // address decode; divisor latch overlays offsets 0 and 1
  wire div_sel = o_line_control[uart_regs_pkg::LCTRL_DIV_EN];
  wire hit_hold = (i_addr == uart_regs_pkg::OFS_HOLD);
  wire hit_ien = (i_addr == uart_regs_pkg::OFS_IEN);
  wire wr_tx_holding = i_wr && hit_hold && !div_sel;
  wire wr_div_low = i_wr && hit_hold && div_sel;
  wire wr_ien = i_wr && hit_ien && !div_sel;
  wire wr_div_high = i_wr && hit_ien && div_sel;
  wire wr_fctrl = i_wr && (i_addr == uart_regs_pkg::OFS_ISTAT);
  wire wr_lctrl = i_wr && (i_addr == uart_regs_pkg::OFS_LCTRL);
  wire wr_mctrl = i_wr && (i_addr == uart_regs_pkg::OFS_MCTRL);
  wire wr_scratch = i_wr && (i_addr == uart_regs_pkg::OFS_SCRATCH);
  wire rd_rx_holding = i_rd && hit_hold && !div_sel;
  wire rd_istat = i_rd && (i_addr == uart_regs_pkg::OFS_ISTAT);
  wire rd_lstat = i_rd && (i_addr == uart_regs_pkg::OFS_LSTAT);
  wire rd_mstat = i_rd && (i_addr == uart_regs_pkg::OFS_MSTAT);
  // fifo control bits other than enable only land with enable set
  wire fctrl_en_bit = i_wdata[uart_regs_pkg::FCTRL_EN];

  // trigger level from the fifo mode scale and the fifo control select
  always_comb begin
    case ({i_trig_scale, trig_sel_q})
      4'h0: trig_level = 8'h01;
      4'h1: trig_level = 8'h04;
      4'h2: trig_level = 8'h08;
      4'h3: trig_level = 8'h0e;
      4'h4: trig_level = 8'h02;
      4'h5: trig_level = 8'h08;
      4'h6: trig_level = 8'h10;
      4'h7: trig_level = 8'h1c;
      4'h8: trig_level = 8'h04;
      4'h9: trig_level = 8'h10;
      4'ha: trig_level = 8'h20;
      4'hb: trig_level = 8'h38;
      4'hc: trig_level = 8'h08;
      4'hd: trig_level = 8'h20;
      4'he: trig_level = 8'h40;
      4'hf: trig_level = 8'h70;
      default: trig_level = 8'h01;
    endcase
  end

  // line status assembly
  wire rx_ready = !i_rx_empty;
  wire head_pe = rx_ready && i_rx_head_parity_err;
  wire head_fe = rx_ready && i_rx_head_framing_err;
  wire head_bi = rx_ready && i_rx_head_break;
  wire global_err = o_fifo_en && i_rx_any_err;
  wire [7:0] lstat = {global_err, i_tx_all_empty, i_tx_holding_empty, head_bi,
                      head_fe, head_pe, overrun_q, rx_ready};
  wire [7:0] mstat = {~modem_sync_q, delta_q};

  // pending sources after the enable mask
  wire line_int = ien_q[uart_regs_pkg::IEN_LINE] && (lstat[4:1] != 4'h0);
  wire level_hit = (i_rx_level >= trig_level);
  wire rx_full_int = o_fifo_en ? level_hit : rx_ready;
  wire rx_data_int = ien_q[uart_regs_pkg::IEN_RX_DATA] && rx_full_int;
  wire tmo_int = ien_q[uart_regs_pkg::IEN_RX_DATA] && timeout;
  wire tx_int = ien_q[uart_regs_pkg::IEN_TX_EMPTY] && tx_pend_q;
  wire modem_int = ien_q[uart_regs_pkg::IEN_MODEM] && (delta_q != 4'h0);

  // only the highest pending source is shown; the rest wait their turn
  always_comb begin
    if (line_int) begin
      src_code = uart_regs_pkg::SRC_LINE;
    end else if (tmo_int) begin
      src_code = uart_regs_pkg::SRC_TIMEOUT;
    end else if (rx_data_int) begin
      src_code = uart_regs_pkg::SRC_RX_DATA;
    end else if (tx_int) begin
      src_code = uart_regs_pkg::SRC_TX_READY;
    end else if (modem_int) begin
      src_code = uart_regs_pkg::SRC_MODEM;
    end else begin
      src_code = uart_regs_pkg::SRC_NONE;
    end
  end
  wire [7:0] istat = {o_fifo_en, o_fifo_en, 2'b00, src_code};
  wire any_pending = (src_code != uart_regs_pkg::SRC_NONE);

  // read data selection
  always_comb begin
    case (i_addr)
      uart_regs_pkg::OFS_HOLD: rd_mux = div_sel ? div_low_q : i_rx_head;
      uart_regs_pkg::OFS_IEN: rd_mux = div_sel ? div_high_q : {4'h0, ien_q};
      uart_regs_pkg::OFS_ISTAT: rd_mux = istat;
      uart_regs_pkg::OFS_LCTRL: rd_mux = o_line_control;
      uart_regs_pkg::OFS_MCTRL: rd_mux = o_modem_control;
      uart_regs_pkg::OFS_LSTAT: rd_mux = lstat;
      uart_regs_pkg::OFS_MSTAT: rd_mux = mstat;
      uart_regs_pkg::OFS_SCRATCH: rd_mux = scratch_q;
      default: rd_mux = 8'h00;
    endcase
  end

  // receive timeout: frame length from word length, parity and stop bits
  wire [6:0] frame_bits = uart_regs_pkg::FRAME_BASE_BITS + {5'h00, o_line_control[1:0]}
                        + {6'h00, o_line_control[uart_regs_pkg::LCTRL_PAR_EN]}
                        + {6'h00, o_line_control[uart_regs_pkg::LCTRL_STOP]};
  wire [6:0] tmo_limit = 7'((frame_bits * uart_regs_pkg::TMO_CHARS) + uart_regs_pkg::TMO_BITS);

  // timer runs only in fifo mode with data waiting; new data or a read restarts it
  wire tmo_run = o_fifo_en && rx_ready;
  wire tmo_restart = i_rx_char_in || rd_rx_holding;

  rx_timeout_timer u_timer (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_enable(tmo_run),
    .i_restart(tmo_restart),
    .i_bit_tick(i_bit_tick),
    .i_limit(tmo_limit),
    .o_expired(timeout)
  );

  // sticky flags; a new event in the clearing cycle wins
  wire tx_rise = i_tx_holding_empty && !tx_empty_prev_q;
  wire tx_enable_rise = wr_ien && i_wdata[uart_regs_pkg::IEN_TX_EMPTY]
                      && !ien_q[uart_regs_pkg::IEN_TX_EMPTY] && i_tx_holding_empty;
  wire tx_clear = wr_tx_holding || (rd_istat && src_code == uart_regs_pkg::SRC_TX_READY);
  always_comb begin
    overrun_d = i_rx_overrun ? 1'b1 : (rd_lstat ? 1'b0 : overrun_q);
    tx_pend_d = (tx_rise || tx_enable_rise) ? 1'b1 : (tx_clear ? 1'b0 : tx_pend_q);
  end

  // modem pins: three flops each, then a sticky delta; a change in the read cycle wins
  wire [3:0] modem_pins_b = {i_cd_b, i_ri_b, i_dsr_b, i_cts_b};
  for (genvar g = 0; g < 4; g++) begin : g_modem
    wire pin_changed = modem_sync_q[g] ^ modem_prev_q[g];
    assign delta_d[g] = pin_changed | (rd_mstat ? 1'b0 : delta_q[g]);
    // reset to the inactive level so release gives no false delta
    always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
        modem_meta_q[g] <= 1'b1;
        modem_sync_q[g] <= 1'b1;
        modem_prev_q[g] <= 1'b1;
        delta_q[g] <= 1'b0;
      end else begin
        modem_meta_q[g] <= modem_pins_b[g];
        modem_sync_q[g] <= modem_meta_q[g];
        modem_prev_q[g] <= modem_sync_q[g];
        delta_q[g] <= delta_d[g];
      end
    end
  end

  // status flags and pipelined interrupt output
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      overrun_q <= 1'b0;
      tx_pend_q <= 1'b0;
      tx_empty_prev_q <= 1'b1;
      o_irq <= 1'b0;
    end else begin
      overrun_q <= overrun_d;
      tx_pend_q <= tx_pend_d;
      tx_empty_prev_q <= i_tx_holding_empty;
      o_irq <= any_pending;
    end
  end

  // read port answers one cycle after the strobe
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_rdata <= 8'h00;
      o_rx_pop <= 1'b0;
    end else begin
      o_rdata <= i_rd ? rd_mux : o_rdata;
      o_rx_pop <= rd_rx_holding;
    end
  end

  // host writable registers
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      ien_q <= uart_regs_pkg::RST_IEN;
      div_low_q <= uart_regs_pkg::RST_DIV_LOW;
      div_high_q <= uart_regs_pkg::RST_DIV_HIGH;
      o_line_control <= uart_regs_pkg::RST_LCTRL;
      o_modem_control <= uart_regs_pkg::RST_MCTRL;
      scratch_q <= uart_regs_pkg::RST_SCRATCH;
    end else begin
      if (wr_ien) begin
        ien_q <= i_wdata[3:0];
      end
      if (wr_div_low) begin
        div_low_q <= i_wdata;
      end
      if (wr_div_high) begin
        div_high_q <= i_wdata;
      end
      if (wr_lctrl) begin
        o_line_control <= i_wdata;
      end
      if (wr_mctrl) begin
        o_modem_control <= i_wdata;
      end
      if (wr_scratch) begin
        scratch_q <= i_wdata;
      end
    end
  end

  // fifo control: resets are one-cycle pulses, cleared by hardware
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_fifo_en <= 1'b0;
      trig_sel_q <= 2'b00;
      o_rx_fifo_reset <= 1'b0;
      o_tx_fifo_reset <= 1'b0;
    end else begin
      o_rx_fifo_reset <= wr_fctrl && fctrl_en_bit && i_wdata[uart_regs_pkg::FCTRL_RX_RST];
      o_tx_fifo_reset <= wr_fctrl && fctrl_en_bit && i_wdata[uart_regs_pkg::FCTRL_TX_RST];
      if (wr_fctrl) begin
        o_fifo_en <= fctrl_en_bit;
      end
      if (wr_fctrl && fctrl_en_bit) begin
        trig_sel_q <= i_wdata[uart_regs_pkg::FCTRL_TRIG_LO +: 2];
      end
    end
  end

  // transmit holding write handed to the engine as a pulse
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      o_tx_push <= 1'b0;
      o_tx_data <= 8'h00;
      o_divisor <= {uart_regs_pkg::RST_DIV_HIGH, uart_regs_pkg::RST_DIV_LOW};
    end else begin
      o_tx_push <= wr_tx_holding;
      o_tx_data <= wr_tx_holding ? i_wdata : o_tx_data;
      o_divisor <= {div_high_q, div_low_q};
    end
  end
endmodule
`default_nettype wire

// *** bench/uart_regs_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
module uart_regs_chk (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // host port
  input wire logic [2:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic o_irq,
  // engine side
  input wire logic i_rx_empty,
  input wire logic i_rx_overrun,
  input wire logic i_rx_any_err,
  input wire logic i_tx_holding_empty,
  input wire logic i_tx_all_empty,
  input wire logic o_rx_pop,
  input wire logic o_tx_push,
  input wire logic [7:0] o_tx_data,
  input wire logic o_fifo_en,
  input wire logic o_rx_fifo_reset,
  input wire logic o_tx_fifo_reset,
  input wire logic [7:0] o_line_control
);
  logic [3:0] ien_q;
  logic latch_on;
  logic rd_ls;
  logic ovr_pend_q;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  // divisor window hides holding and enable registers
  assign latch_on = o_line_control[7];
  assign rd_ls = i_rd && (i_addr == uart_regs_pkg::OFS_LSTAT);
  // shadow of the enable mask, so a quiet irq can be demanded
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      ien_q <= 4'h0;
    end else if (i_wr && (i_addr == uart_regs_pkg::OFS_IEN) && !latch_on) begin
      ien_q <= i_wdata[3:0];
    end
  end
  // overrun seen but not yet reported by a line status read
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_b) begin
      ovr_pend_q <= 1'b0;
    end else begin
      ovr_pend_q <= i_rx_overrun || (ovr_pend_q && !rd_ls);
    end
  end
  property p_tx_push;
    i_wr && (i_addr == uart_regs_pkg::OFS_HOLD) && !latch_on |=> o_tx_push && (o_tx_data == $past(i_wdata));
  endproperty
  property p_div_write;
    i_wr && (i_addr == uart_regs_pkg::OFS_HOLD) && latch_on |=> !o_tx_push;
  endproperty
  property p_rx_pop;
    i_rd && (i_addr == uart_regs_pkg::OFS_HOLD) && !latch_on |=> o_rx_pop;
  endproperty
  property p_ien_rsvd;
    i_rd && (i_addr == uart_regs_pkg::OFS_IEN) && !latch_on |=> o_rdata[7:4] == 4'h0;
  endproperty
  property p_ls_ready;
    rd_ls |=> o_rdata[0] == !$past(i_rx_empty);
  endproperty
  property p_ls_tx;
    rd_ls |=> o_rdata[6:5] == {$past(i_tx_all_empty), $past(i_tx_holding_empty)};
  endproperty
  property p_ls_glob;
    rd_ls |=> o_rdata[7] == ($past(i_rx_any_err) && $past(o_fifo_en));
  endproperty
  property p_overrun;
    rd_ls && ovr_pend_q |=> o_rdata[1];
  endproperty
  property p_fifo_rst;
    i_wr && (i_addr == uart_regs_pkg::OFS_ISTAT) |=> (o_rx_fifo_reset == (($past(i_wdata) & 8'h03) == 8'h03))
      && (o_tx_fifo_reset == (($past(i_wdata) & 8'h05) == 8'h05));
  endproperty
  property p_line_irq;
    ien_q[2] && i_rx_overrun |-> ##[1:3] o_irq;
  endproperty
  property p_masked;
    (ien_q == 4'h0) [*2] |-> !o_irq;
  endproperty
  property p_fifo_bits;
    i_rd && (i_addr == uart_regs_pkg::OFS_ISTAT) |=> o_rdata[7:6] == {2{$past(o_fifo_en)}};
  endproperty
  a_tx_push: assert property (p_tx_push) else $error("tx write gave no push");
  a_div_write: assert property (p_div_write) else $error("divisor write pushed tx");
  a_rx_pop: assert property (p_rx_pop) else $error("rx read gave no pop");
  a_ien_rsvd: assert property (p_ien_rsvd) else $error("enable upper bits set");
  a_ls_ready: assert property (p_ls_ready) else $error("data ready bit wrong");
  a_ls_tx: assert property (p_ls_tx) else $error("tx empty bits wrong");
  a_ls_glob: assert property (p_ls_glob) else $error("global error bit wrong");
  a_overrun: assert property (p_overrun) else $error("overrun not reported");
  a_line_irq: assert property (p_line_irq) else $error("line irq missing");
  a_masked: assert property (p_masked) else $error("irq while masked");
  a_fifo_bits: assert property (p_fifo_bits) else $error("fifo bits wrong");
  a_fifo_rst: assert property (p_fifo_rst) else $error("fifo reset pulse wrong");
  // main scenarios reached
  c_push: cover property (o_tx_push);
  c_line: cover property (ien_q[2] && i_rx_overrun);
  c_ovr: cover property (rd_ls ##1 o_rdata[1]);
endmodule
bind uart_regs_irq_enable uart_regs_chk uart_regs_chk_i (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
  .i_addr(i_addr), .i_rd(i_rd), .i_wr(i_wr), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_irq(o_irq),
  .i_rx_empty(i_rx_empty), .i_rx_overrun(i_rx_overrun), .i_rx_any_err(i_rx_any_err),
  .i_tx_holding_empty(i_tx_holding_empty), .i_tx_all_empty(i_tx_all_empty), .o_rx_pop(o_rx_pop),
  .o_tx_push(o_tx_push), .o_tx_data(o_tx_data), .o_fifo_en(o_fifo_en), .o_rx_fifo_reset(o_rx_fifo_reset),
  .o_tx_fifo_reset(o_tx_fifo_reset), .o_line_control(o_line_control));
`default_nettype wire

// *** bench/uart_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module uart_host_model (
  // clock
  input wire logic i_clk_sys,
  // register port toward the block
  input wire logic [7:0] i_rdata,
  output logic [2:0] o_addr,
  output logic o_rd,
  output logic o_wr,
  output logic [7:0] o_wdata
);
  // idle bus at time zero
  initial begin
    o_addr = 3'h0;
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_wdata = 8'h00;
  end
  // one strobe per access; data inverted once released so stale values never match
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk_sys) #1;
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(posedge i_clk_sys) #1;
    o_wr = 1'b0;
    o_wdata = ~d;
  endtask
  // register reads of any offset, data taken once the registered answer settled
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge i_clk_sys) #1;
    o_addr = a;
    o_rd = 1'b1;
    @(posedge i_clk_sys) #1;
    o_rd = 1'b0;
    @(posedge i_clk_sys) #1;
    d = i_rdata;
  endtask
endmodule
`default_nettype wire

// *** bench/uart_regs_irq_enable_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module uart_regs_irq_enable_tb;
  typedef struct packed {logic [2:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  logic i_clk_sys, i_rst_b, i_rd, i_wr, i_rx_char_in, i_rx_empty, i_rx_overrun, i_pe, i_fe, i_bi;
  logic i_any_err, i_bit_tick, i_hold_empty, i_all_empty, i_cts_b, o_irq, o_rx_pop, o_tx_push, o_fifo_en;
  logic [2:0] i_addr;
  logic [7:0] i_wdata, o_rdata, i_rx_level, o_tx_data, o_line_control, rd_v;
  logic [15:0] o_divisor;
  int error_cnt, num_checks;
  row_t rows[5] = '{'{3'h3, 8'h1b, 8'h1b}, '{3'h4, 8'h13, 8'h13}, '{3'h7, 8'ha5, 8'ha5},
    '{3'h1, 8'hf0, 8'h00}, '{3'h7, 8'h5a, 8'h5a}};
  uart_regs_irq_enable uart_regs_irq_enable_i (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_addr(i_addr),
    .i_rd(i_rd), .i_wr(i_wr), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_irq(o_irq), .i_rx_char_in(i_rx_char_in),
    .i_rx_head(8'h3c), .i_rx_empty(i_rx_empty), .i_rx_level(i_rx_level), .i_rx_overrun(i_rx_overrun),
    .i_rx_head_parity_err(i_pe), .i_rx_head_framing_err(i_fe), .i_rx_head_break(i_bi),
    .i_rx_any_err(i_any_err), .i_trig_scale(2'h0), .i_bit_tick(i_bit_tick), .i_tx_holding_empty(i_hold_empty),
    .i_tx_all_empty(i_all_empty), .i_cts_b(i_cts_b), .i_dsr_b(1'b1), .i_ri_b(1'b1), .i_cd_b(1'b1),
    .o_rx_pop(o_rx_pop), .o_tx_push(o_tx_push), .o_tx_data(o_tx_data), .o_fifo_en(o_fifo_en),
    .o_rx_fifo_reset(), .o_tx_fifo_reset(), .o_line_control(o_line_control), .o_modem_control(),
    .o_divisor(o_divisor));
  uart_host_model host (.i_clk_sys(i_clk_sys), .i_rdata(o_rdata), .o_addr(i_addr), .o_rd(i_rd), .o_wr(i_wr),
    .o_wdata(i_wdata));
  // 40 MHz clock
  initial begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask
  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    host.rd(a, rd_v);
    check({8'h00, rd_v}, {8'h00, e});
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask
  task automatic results;
    $display("checks=%0d errors=%0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // bounded wait on the interrupt line; running out ends the run
  task automatic wait_irq(input logic v);
    int k;
    for (k = 0; k < 200 && o_irq !== v; k++) cyc(1);
    check({15'h0, o_irq}, {15'h0, v});
    if (o_irq !== v) results();
  endtask
  initial begin
    {i_rst_b, i_rx_char_in, i_rx_overrun, i_pe, i_fe, i_bi, i_any_err, i_bit_tick} = 8'h00;
    {i_rx_empty, i_hold_empty, i_all_empty, i_cts_b} = 4'hf;
    i_rx_level = 8'h00;
    cyc(12);
    i_rst_b = 1'b1;
    rdc(3'h1, 8'h00);
    rdc(3'h2, 8'h01);
    rdc(3'h5, 8'h60);
    host.wr(3'h3, 8'h80);
    host.wr(3'h0, 8'h34);
    host.wr(3'h1, 8'h12);
    cyc(2);
    check(o_divisor, 16'h1234);
    foreach (rows[i]) begin
      host.wr(rows[i].a, rows[i].d);
      rdc(rows[i].a, rows[i].e);
    end
    // tx ready raised at once when enabled while empty, cleared by a status read
    host.wr(3'h1, 8'h02);
    wait_irq(1'b1);
    rdc(3'h2, 8'h02);
    wait_irq(1'b0);
    // raised again, this time cleared by a holding write
    host.wr(3'h1, 8'h00);
    host.wr(3'h1, 8'h02);
    wait_irq(1'b1);
    host.wr(3'h0, 8'h5a);
    wait_irq(1'b0);
    // line, rx data and tx ready pending together, served in priority order; modem raised afterwards
    host.wr(3'h2, 8'h01);
    host.wr(3'h1, 8'h00);
    host.wr(3'h1, 8'h0f);
    {i_rx_empty, i_rx_level, i_rx_char_in, i_rx_overrun} = {1'b0, 8'h01, 2'b11};
    cyc(1);
    {i_rx_char_in, i_rx_overrun} = 2'b00;
    rdc(3'h2, 8'hc6);
    rdc(3'h5, 8'h63);
    rdc(3'h2, 8'hc4);
    {i_rx_empty, i_rx_level} = {1'b1, 8'h00};
    rdc(3'h2, 8'hc2);
    rdc(3'h2, 8'hc1);
    i_cts_b = 1'b0;
    wait_irq(1'b1);
    rdc(3'h2, 8'hc0);
    rdc(3'h6, 8'h11);
    rdc(3'h2, 8'hc1);
    // receive timeout below a trigger of four; both fifo resets pulse
    host.wr(3'h2, 8'h47);
    {i_rx_empty, i_rx_level, i_rx_char_in, i_bit_tick} = {1'b0, 8'h01, 2'b11};
    cyc(1);
    i_rx_char_in = 1'b0;
    wait_irq(1'b1);
    rdc(3'h2, 8'hcc);
    rdc(3'h0, 8'h3c);
    i_bit_tick = 1'b0;
    rdc(3'h2, 8'hc1);
    i_rx_level = 8'h04;
    rdc(3'h2, 8'hc4);
    // polled mode with head errors present
    host.wr(3'h1, 8'h00);
    {i_pe, i_fe, i_bi, i_any_err, i_all_empty} = 5'b10110;
    rdc(3'h5, 8'hb5);
    check({15'h0, o_irq}, 16'h0000);
    // head errors interrupt once the line source is enabled
    host.wr(3'h1, 8'h04);
    wait_irq(1'b1);
    rdc(3'h2, 8'hc6);
    // non-fifo mode: data ready alone raises rx data, global error hidden
    host.wr(3'h1, 8'h01);
    host.wr(3'h2, 8'h00);
    rdc(3'h2, 8'h04);
    rdc(3'h5, 8'h35);
    results();
  end
endmodule
`default_nettype wire
